// [logic/mcm_memory_crc_monitor.v]
// Purpose: background crc checker for code and calibration memory, plus ident registers
// Assumes: memory words are presented on a read port with one cycle latency
// Notes: register reads are paged; reads return data one cycle after the strobe
`timescale 1ns/100ps
`include "mcm_consts.vh"
module mcm_memory_crc_monitor #(
  parameter CODE_WORDS = 1024,
  parameter CAL_WORDS = 256,
  parameter AW = 12,
  parameter [15:0] YEAR_BCD = 16'h2016,
  parameter [15:0] BOOT_REVISION = 16'h0100,
  parameter [15:0] SERIAL_VAL = 16'h0001,
  parameter [31:0] CODE_SIGNATURE = 32'h0000_0000,
  parameter [31:0] CAL_SIGNATURE = 32'h0000_0000
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  // memory read port (code region then calibration region)
  output reg mem_rd_en_r,
  output reg mem_sel_cal_r,
  output reg [AW-1:0] mem_addr_r,
  input wire [15:0] mem_rdata,
  // paged register read port
  input wire [7:0] reg_page,
  input wire [6:0] reg_addr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_r,
  output reg reg_rvalid_r,
  // system error flags, bit 2 is the memory error
  output reg [15:0] system_error_flags_r,
  output reg pass_done_r
);
  // sweep states, two-bit binary codes
  localparam ST_CODE = 2'd0;
  localparam ST_CAL = 2'd1;
  localparam ST_TAIL = 2'd2;
  localparam ST_LATCH = 2'd3;

  reg [1:0] state_r;
  reg [AW-1:0] cnt_r;
  reg data_vld_r;
  reg data_cal_r;
  reg [31:0] code_acc_r;
  reg [31:0] cal_acc_r;
  reg [31:0] code_cmp_r;
  reg [31:0] cal_cmp_r;
  reg cmp_pend_r;
  wire [31:0] acc_sel;
  wire [31:0] acc_next;
  wire [31:0] code_fin;
  wire [31:0] cal_fin;
  wire [31:0] cal_last;

  // one shared crc stepper; regions never overlap in time
  assign acc_sel = data_cal_r ? cal_acc_r : code_acc_r;
  mcm_crc32_step u_step (
    .crc_in(acc_sel),
    .data_in(mem_rdata),
    .crc_out(acc_next)
  );
  assign code_fin = code_acc_r ^ `MCM_CRC_XOROUT;

  // ****************************************
  // last calibration word fold
  // ****************************************
  // read latency puts the final cal word on the port in the latch cycle
  // itself; folding it through the stepper here keeps the pass at
  // words plus two cycles instead of adding a second drain state
  assign cal_last = (data_vld_r && data_cal_r) ? acc_next : cal_acc_r;
  assign cal_fin = cal_last ^ `MCM_CRC_XOROUT;

  // ****************************************
  // sweep sequencer
  // ****************************************
  // address issue runs free; the tail state drains the next-to-last read word
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_CODE;
      cnt_r <= {AW{1'b0}};
      mem_rd_en_r <= 1'b0;
      mem_sel_cal_r <= 1'b0;
      mem_addr_r <= {AW{1'b0}};
      data_vld_r <= 1'b0;
      data_cal_r <= 1'b0;
      pass_done_r <= 1'b0;
    end else if (clk_en) begin
      data_vld_r <= mem_rd_en_r;
      data_cal_r <= mem_sel_cal_r;
      pass_done_r <= 1'b0;
      case (state_r)
        ST_CODE: begin
          mem_rd_en_r <= 1'b1;
          mem_sel_cal_r <= 1'b0;
          mem_addr_r <= cnt_r;
          if (cnt_r == CODE_WORDS - 1) begin
            cnt_r <= {AW{1'b0}};
            state_r <= ST_CAL;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_CAL: begin
          mem_rd_en_r <= 1'b1;
          mem_sel_cal_r <= 1'b1;
          mem_addr_r <= cnt_r;
          if (cnt_r == CAL_WORDS - 1) begin
            cnt_r <= {AW{1'b0}};
            state_r <= ST_TAIL;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_TAIL: begin
          mem_rd_en_r <= 1'b0;
          state_r <= ST_LATCH;
        end
        ST_LATCH: begin
          pass_done_r <= 1'b1;
          state_r <= ST_CODE; // next pass starts straight away
        end
        default: begin
          state_r <= ST_CODE;
        end
      endcase
    end
  end

  // ****************************************
  // crc accumulation and result capture
  // ****************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      code_acc_r <= `MCM_CRC_INIT;
      cal_acc_r <= `MCM_CRC_INIT;
      code_cmp_r <= 32'h0000_0000;
      cal_cmp_r <= 32'h0000_0000;
      cmp_pend_r <= 1'b0;
    end else if (clk_en) begin
      cmp_pend_r <= 1'b0;
      if (state_r == ST_LATCH) begin
        // all four words in one edge so a read never mixes passes
        code_cmp_r <= code_fin;
        cal_cmp_r <= cal_fin;
        code_acc_r <= `MCM_CRC_INIT;
        cal_acc_r <= `MCM_CRC_INIT;
        cmp_pend_r <= 1'b1;
      end else if (data_vld_r) begin
        if (data_cal_r) begin
          cal_acc_r <= acc_next;
        end else begin
          code_acc_r <= acc_next;
        end
      end
    end
  end

  // ****************************************
  // compare against factory signatures
  // ****************************************
  // compare uses the stored registers, one cycle after the capture
  // the bit is rewritten every pass, so a later clean pass clears it;
  // there is no host clear, which keeps the flag free of set/clear races
  always @(posedge clk_sys) begin
    if (rst) begin
      system_error_flags_r <= `MCM_RST_ZERO16;
    end else if (clk_en && cmp_pend_r) begin
      system_error_flags_r[`MCM_ERR_MEM_BIT] <=
        (cal_cmp_r[15:0] != CAL_SIGNATURE[15:0]) || (cal_cmp_r[31:16] != CAL_SIGNATURE[31:16]) ||
        (code_cmp_r[15:0] != CODE_SIGNATURE[15:0]) || (code_cmp_r[31:16] != CODE_SIGNATURE[31:16]);
    end
  end

  // ****************************************
  // paged register read
  // ****************************************
  // signatures are parameters, computed words come from the capture regs
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r <= `MCM_RST_ZERO16;
      reg_rvalid_r <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= `MCM_RST_ZERO16; // unmapped reads as zero
        if (reg_page == `MCM_PAGE_IDENT) begin
          case (reg_addr)
            `MCM_OFS_FACTORY_CONFIG_YEAR: reg_rdata_r <= YEAR_BCD;
            `MCM_OFS_BOOTLOADER_REVISION: reg_rdata_r <= BOOT_REVISION;
            default: reg_rdata_r <= `MCM_RST_ZERO16;
          endcase
        end else if (reg_page == `MCM_PAGE_CRC) begin
          case (reg_addr)
            `MCM_OFS_CALIB_SIG_LOW: reg_rdata_r <= CAL_SIGNATURE[15:0];
            `MCM_OFS_CALIB_SIG_HIGH: reg_rdata_r <= CAL_SIGNATURE[31:16];
            `MCM_OFS_CALIB_CMP_LOW: reg_rdata_r <= cal_cmp_r[15:0];
            `MCM_OFS_CALIB_CMP_HIGH: reg_rdata_r <= cal_cmp_r[31:16];
            `MCM_OFS_PROG_SIG_LOW: reg_rdata_r <= CODE_SIGNATURE[15:0];
            `MCM_OFS_PROG_SIG_HIGH: reg_rdata_r <= CODE_SIGNATURE[31:16];
            `MCM_OFS_PROG_CMP_LOW: reg_rdata_r <= code_cmp_r[15:0];
            `MCM_OFS_PROG_CMP_HIGH: reg_rdata_r <= code_cmp_r[31:16];
            `MCM_OFS_LOT_SERIAL: reg_rdata_r <= SERIAL_VAL;
            default: reg_rdata_r <= `MCM_RST_ZERO16;
          endcase
        end
      end
    end
  end
endmodule // mcm_memory_crc_monitor

// [shared/mcm_consts.vh]
// Purpose: constants for the memory crc monitor
// Assumes: paged 16-bit register space, byte offsets within a page
// Notes: offsets are the even (low) byte address of each register
`ifndef MCM_CONSTS_VH
`define MCM_CONSTS_VH
// ****************************************
// page numbers
// ****************************************
`define MCM_PAGE_IDENT 8'h03
`define MCM_PAGE_CRC 8'h04
// ****************************************
// register offsets
// ****************************************
`define MCM_OFS_FACTORY_CONFIG_YEAR 7'h7c
`define MCM_OFS_BOOTLOADER_REVISION 7'h7e
`define MCM_OFS_CALIB_SIG_LOW 7'h04
`define MCM_OFS_CALIB_SIG_HIGH 7'h06
`define MCM_OFS_CALIB_CMP_LOW 7'h08
`define MCM_OFS_CALIB_CMP_HIGH 7'h0a
`define MCM_OFS_PROG_SIG_LOW 7'h0c
`define MCM_OFS_PROG_SIG_HIGH 7'h0e
`define MCM_OFS_PROG_CMP_LOW 7'h10
`define MCM_OFS_PROG_CMP_HIGH 7'h12
`define MCM_OFS_LOT_SERIAL 7'h20
// ****************************************
// fields and crc definition
// ****************************************
`define MCM_ERR_MEM_BIT 2
`define MCM_CRC_POLY 32'h04c1_1db7
`define MCM_CRC_INIT 32'hffff_ffff
`define MCM_CRC_XOROUT 32'hffff_ffff
`define MCM_RST_ZERO16 16'h0000
`endif

// [logic/mcm_crc32_step.v]
// Purpose: one 16-bit word step of a 32-bit crc, msb first
// Assumes: caller holds the running value
// Notes: purely combinational
`timescale 1ns/100ps
`include "mcm_consts.vh"
module mcm_crc32_step (
  input wire [31:0] crc_in,
  input wire [15:0] data_in,
  output reg [31:0] crc_out
);
  integer i;
  reg fb;
  // ****************************************
  // bitwise shift, 16 bits per call
  // ****************************************
  always @* begin
    crc_out = crc_in;
    fb = 1'b0;
    for (i = 15; i >= 0; i = i - 1) begin
      fb = crc_out[31] ^ data_in[i];
      crc_out = {crc_out[30:0], 1'b0} ^ (fb ? `MCM_CRC_POLY : 32'h0000_0000);
    end
  end
endmodule // mcm_crc32_step

// [verif/mcm_chk_assertions.sv]
// Purpose: port checker for the memory crc monitor
// Assumes: a low clk_en stalls the block, and every check is held off then
// Notes: bound to the top module below
`timescale 1ns/100ps
module mcm_chk #(
  parameter CODE_WORDS = 4,
  parameter CAL_WORDS = 2,
  parameter [15:0] YEAR_BCD = 16'h0000,
  parameter [15:0] BOOT_REVISION = 16'h0000,
  parameter [15:0] SERIAL_VAL = 16'h0000,
  parameter [31:0] CODE_SIGNATURE = 32'h0000_0000
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire mem_rd_en_r,
  input wire [7:0] reg_page,
  input wire [6:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_r,
  input wire reg_rvalid_r,
  input wire [15:0] system_error_flags_r,
  input wire pass_done_r
);
  localparam int PER = CODE_WORDS + CAL_WORDS + 2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);
  // read port answers and fixed words
  a_read_answer: assert property (reg_rd && clk_en |=> reg_rvalid_r) else $error("read not answered");
  a_year_value: assert property (reg_rd && reg_page == 8'h03 && reg_addr == 7'h7c |=> reg_rdata_r == YEAR_BCD)
    else $error("year word wrong");
  a_boot_value: assert property (reg_rd && reg_page == 8'h03 && reg_addr == 7'h7e |=> reg_rdata_r == BOOT_REVISION)
    else $error("boot word wrong");
  a_serial_value: assert property (reg_rd && reg_page == 8'h04 && reg_addr == 7'h20 |=> reg_rdata_r == SERIAL_VAL)
    else $error("serial word wrong");
  a_sig_low: assert property (reg_rd && reg_page == 8'h04 && reg_addr == 7'h0c |=> reg_rdata_r == CODE_SIGNATURE[15:0])
    else $error("signature word wrong");
  // sweep timing and flag behaviour
  a_flag_spare: assert property (system_error_flags_r[15:3] == 13'h0 && system_error_flags_r[1:0] == 2'h0)
    else $error("spare flag set");
  a_pass_period: assert property (pass_done_r |-> ##PER pass_done_r) else $error("pass period wrong");
  a_sweep_start: assert property ($fell(rst) |-> ##[1:2] mem_rd_en_r) else $error("sweep idle");
  a_flag_at_pass: assert property ($changed(system_error_flags_r) |-> $past(pass_done_r))
    else $error("flag moved off pass");
  c_pass: cover property (pass_done_r);
  c_err: cover property (system_error_flags_r[2]);
  c_read: cover property (reg_rvalid_r);
endmodule // mcm_chk
bind mcm_memory_crc_monitor mcm_chk #(.CODE_WORDS(CODE_WORDS), .CAL_WORDS(CAL_WORDS), .YEAR_BCD(YEAR_BCD),
  .BOOT_REVISION(BOOT_REVISION), .SERIAL_VAL(SERIAL_VAL), .CODE_SIGNATURE(CODE_SIGNATURE)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .mem_rd_en_r(mem_rd_en_r), .reg_page(reg_page),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
  .system_error_flags_r(system_error_flags_r), .pass_done_r(pass_done_r));

// [verif/mcm_mem_model.sv]
// Purpose: sram model behind the monitor read port
// Assumes: one cycle read latency
// Notes: corrupt flips bit 0 of every word
`timescale 1ns/100ps
module mcm_mem_model (
  input wire clk_sys,
  input wire clk_en,
  input wire mem_rd_en_r,
  input wire mem_sel_cal_r,
  input wire [11:0] mem_addr_r,
  input wire corrupt,
  output reg [15:0] mem_rdata
);
  // idle cycles show the inverse so stale data cannot pass
  initial mem_rdata = 16'h0000;
  // the port stalls with the monitor, so a frozen read keeps its word
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (mem_rd_en_r) mem_rdata <= 16'ha5c3 ^ {3'h0, mem_sel_cal_r, mem_addr_r} ^ {15'h0, corrupt};
      else mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mcm_mem_model

// [verif/testbench.sv]
// Purpose: self-checking bench for the memory crc monitor
// Assumes: short regions of 4 and 2 words
// Notes: expected crcs are rebuilt here from the word pattern
`timescale 1ns/100ps
`include "mcm_consts.vh"
module testbench;
  localparam CW = 4;
  localparam LW = 2;
  reg clk_sys = 0;
  reg rst = 1;
  reg reg_rd = 0;
  reg corrupt = 0;
  reg clk_en = 1;
  reg [7:0] reg_page = 8'h00;
  reg [6:0] reg_addr = 7'h00;
  integer err_count = 0;
  integer samples_checked = 0;
  integer seed = 58;
  integer n, m, r;
  wire mem_rd_en_r, mem_sel_cal_r, reg_rvalid_r, pass_done_r;
  wire [11:0] mem_addr_r;
  wire [15:0] mem_rdata, reg_rdata_r, system_error_flags_r;
  // reference crc, msb first per word
  function [31:0] crc_of(input sel, input integer cnt, input cor);
    integer i, b;
    reg [31:0] c;
    reg [15:0] w;
    begin
      c = `MCM_CRC_INIT;
      for (i = 0; i < cnt; i = i + 1) begin
        w = 16'ha5c3 ^ {3'h0, sel, i[11:0]} ^ {15'h0, cor};
        for (b = 15; b >= 0; b = b - 1) c = (c << 1) ^ ((c[31] ^ w[b]) ? `MCM_CRC_POLY : 32'h0);
      end
      crc_of = c ^ `MCM_CRC_XOROUT;
    end
  endfunction
  localparam [31:0] CODE_SIG = crc_of(1'b0, CW, 1'b0);
  localparam [31:0] CAL_SIG = crc_of(1'b1, LW, 1'b0);
  // register map model; anything unlisted reads zero
  function [15:0] exp_reg(input [7:0] p, input [6:0] a);
    reg [31:0] cc, lc;
    begin
      cc = crc_of(1'b0, CW, corrupt);
      lc = crc_of(1'b1, LW, corrupt);
      case ({p, a})
        {8'h03, 7'h7c}: exp_reg = 16'h2019;
        {8'h03, 7'h7e}: exp_reg = 16'h0305;
        {8'h04, 7'h04}: exp_reg = CAL_SIG[15:0];
        {8'h04, 7'h06}: exp_reg = CAL_SIG[31:16];
        {8'h04, 7'h08}: exp_reg = lc[15:0];
        {8'h04, 7'h0a}: exp_reg = lc[31:16];
        {8'h04, 7'h0c}: exp_reg = CODE_SIG[15:0];
        {8'h04, 7'h0e}: exp_reg = CODE_SIG[31:16];
        {8'h04, 7'h10}: exp_reg = cc[15:0];
        {8'h04, 7'h12}: exp_reg = cc[31:16];
        {8'h04, 7'h20}: exp_reg = 16'h3c5a;
        default: exp_reg = 16'h0000;
      endcase
    end
  endfunction
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  mcm_memory_crc_monitor #(.CODE_WORDS(CW), .CAL_WORDS(LW), .AW(12), .YEAR_BCD(16'h2019),
    .BOOT_REVISION(16'h0305), .SERIAL_VAL(16'h3c5a), .CODE_SIGNATURE(CODE_SIG), .CAL_SIGNATURE(CAL_SIG)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .mem_rd_en_r(mem_rd_en_r), .mem_sel_cal_r(mem_sel_cal_r),
    .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .reg_page(reg_page), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .system_error_flags_r(system_error_flags_r),
    .pass_done_r(pass_done_r));
  mcm_mem_model mem_u (.clk_sys(clk_sys), .clk_en(clk_en), .mem_rd_en_r(mem_rd_en_r), .mem_sel_cal_r(mem_sel_cal_r),
    .mem_addr_r(mem_addr_r), .corrupt(corrupt), .mem_rdata(mem_rdata));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // one read, entered and left just after an edge
  task rd(input [7:0] p, input [6:0] a);
    begin
      reg_page = p;
      reg_addr = a;
      reg_rd = 1;
      @(posedge clk_sys);
      #1 reg_rd = 0;
      chk({15'h0, reg_rvalid_r}, 16'h0001);
      chk(reg_rdata_r, exp_reg(p, a));
      @(posedge clk_sys);
      #1;
    end
  endtask
  task wait_pass;
    integer k;
    begin
      for (k = 0; k < 40 && pass_done_r !== 1'b1; k = k + 1) begin
        @(posedge clk_sys);
        #1;
      end
      if (k == 40) begin
        err_count = err_count + 1;
        give_verdict;
      end else begin
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
  // clean, corrupted, clean again; two passes so the change has settled
  initial begin
    for (n = 0; n < 20; n = n + 1) @(posedge clk_sys);
    #1 rst = 0;
    for (m = 0; m < 3; m = m + 1) begin
      corrupt = m[0];
      wait_pass;
      wait_pass;
      chk(system_error_flags_r, corrupt ? 16'h0004 : 16'h0000);
      for (n = 0; n < 128; n = n + 2) begin
        rd(8'h03, n[6:0]);
        rd(8'h04, n[6:0]);
      end
      for (n = 0; n < 30; n = n + 1) begin
        r = $random(seed);
        rd({5'h00, r[2:0]}, r[9:3]);
      end
    end
    // an enable drop longer than a pass must freeze the sweep
    clk_en = 0;
    r = {pass_done_r, 3'h0, mem_addr_r};
    for (n = 0; n < 12; n = n + 1) @(posedge clk_sys);
    #1 chk({pass_done_r, 3'h0, mem_addr_r}, r[15:0]);
    clk_en = 1;
    wait_pass;
    wait_pass;
    chk(system_error_flags_r, 16'h0000);
    give_verdict;
  end
endmodule // testbench
